// ---- verilog/elsr_consts.svh ----
// Offsets, field positions, reset values and timing counts of the emulated link status block
`ifndef ELSR_CONSTS_SVH
`define ELSR_CONSTS_SVH

// ****************************************************************
// Register offsets (byte addresses)
// ****************************************************************
`define ELSR_OFF_RP_STS 8'h00
`define ELSR_OFF_EP_STS 8'h04
`define ELSR_OFF_RP_CAP2 8'h08
`define ELSR_OFF_EP_CAP2 8'h0C
`define ELSR_OFF_RP_STS2 8'h10
`define ELSR_OFF_EP_STS2 8'h14
`define ELSR_OFF_CTRL 8'h18

// ****************************************************************
// Field positions
// ****************************************************************
`define ELSR_CTRL_DIS 0
`define ELSR_CTRL_SBR 1
`define ELSR_CTRL_RETRAIN 2
`define ELSR_STS_BW 14
`define ELSR_STS_ABW 15
`define ELSR_STS2_DRS 15

// ****************************************************************
// Hardwired and reset values
// ****************************************************************
`define ELSR_SUP_SPEEDS 7'b000_0111
`define ELSR_SUP_8G_BIT 2
`define ELSR_TGT_RST 4'h3
`define ELSR_SPEED_5G 4'h2
`define ELSR_LINK_WIDTH 6'h01
`define ELSR_DEEMPH 1'b1
`define ELSR_EP_DRS_SUP 1'b1
`define ELSR_EP_FRS_SUP 1'b0
`define ELSR_PRES_DOWN 3'h2
`define ELSR_PRES_UP 3'h4
`define ELSR_PRES_UP_DRS 3'h5
`define ELSR_PRES_EP 3'h0

// ****************************************************************
// Timing
// ****************************************************************
`define ELSR_CLK_NS 4
`define ELSR_RST_DLY_NS 2000
`define ELSR_DIS_DLY_NS 1600
`define ELSR_SBR_DLY_NS 1200
`define ELSR_RTR_DLY_NS 400
`define ELSR_CYC(ns) (((ns) + `ELSR_CLK_NS - 1) / `ELSR_CLK_NS)

`endif

// ---- verilog/elsr_pkg.sv ----
// Types shared by the emulated link status block
package elsr_pkg;
    typedef logic [11:0] elsr_cnt_t;
    typedef logic [3:0] elsr_speed_t;
    typedef enum logic [1:0] {
        ELSR_DLY_RST = 2'b00,
        ELSR_DLY_DIS = 2'b01,
        ELSR_DLY_SBR = 2'b10,
        ELSR_DLY_RTR = 2'b11
    } elsr_dly_sel_t;
endpackage

// ---- verilog/elsr_dly_if.sv ----
// Start, abort, done and busy of one delay timer
`timescale 1ns/10ps
interface elsr_dly_if;
    logic start;
    logic abort;
    logic done;
    logic busy;
    modport ctl (output start, output abort, input done, input busy);
    modport tmr (input start, input abort, output done, output busy);
endinterface

// ---- verilog/elsr_delay.sv ----
// Restartable down counter producing one done pulse
`timescale 1ns/10ps
module elsr_delay #(
    parameter elsr_pkg::elsr_cnt_t CYC = 12'h001
) (
    // Clock and reset
    input wire logic clk_sys_i,
    input wire logic rst_b_i,
    // Control
    elsr_dly_if.tmr dly
);
    elsr_pkg::elsr_cnt_t cnt_reg;
    elsr_pkg::elsr_cnt_t cnt_next;
    logic done_reg;
    wire logic last = (cnt_reg == 12'h001);

    // Abort beats start so a hold rising as the other ends does not arm the timer
    assign cnt_next = dly.abort ? 12'h000 :
                      dly.start ? CYC :
                      (cnt_reg != 12'h000) ? cnt_reg - 12'h001 : 12'h000;

    always_ff @(posedge clk_sys_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            cnt_reg <= 12'h000;
            done_reg <= 1'b0;
        end else begin
            cnt_reg <= cnt_next;
            done_reg <= last & ~dly.abort & ~dly.start;
        end
    end

    assign dly.done = done_reg;
    assign dly.busy = (cnt_reg != 12'h000);
endmodule // elsr_delay

// ---- verilog/elsr_top.sv ----
// Emulated link status, capabilities 2 and status 2 registers for root port and endpoint
`timescale 1ns/10ps
`include "elsr_consts.svh"
module elsr_top (
    // Clock and reset
    input wire logic clk_sys_i,
    input wire logic rst_b_i,
    // Wishbone slave
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_we_i,
    input wire logic [7:0] wb_adr_i,
    input wire logic [3:0] wb_sel_i,
    input wire logic [31:0] wb_dat_i,
    output logic [31:0] wb_dat_o,
    output logic wb_ack_o,
    // DRS message arrival, bit 0 root port, bit 1 endpoint
    input wire logic [1:0] drs_msg_i,
    // Emulated link state
    output logic link_active_o
);
    // ****************************************************************
    // Functions
    // ****************************************************************
    // Word decode, byte offset bits are ignored
    function automatic logic hit(input logic [7:0] adr, input logic [7:0] off);
        hit = (adr[7:2] == off[7:2]);
    endfunction

    function automatic logic [15:0] w1c(input logic [15:0] v, input logic [15:0] m);
        w1c = v & ~m;
    endfunction

    // ****************************************************************
    // Bus decode
    // ****************************************************************
    logic ack_reg;
    logic [31:0] dat_reg;
    logic [31:0] rd_word;
    wire logic req = wb_cyc_i & wb_stb_i;
    // Write takes effect on the edge at which the master sees ack
    wire logic wr_fire = req & wb_we_i & ack_reg;
    wire logic [31:0] wmask = {{8{wb_sel_i[3]}}, {8{wb_sel_i[2]}},
                               {8{wb_sel_i[1]}}, {8{wb_sel_i[0]}}};
    wire logic [31:0] wbits = wb_dat_i & wmask;
    wire logic wr_ctrl = wr_fire & hit(wb_adr_i, `ELSR_OFF_CTRL);
    wire logic [1:0] wr_sts = {wr_fire & hit(wb_adr_i, `ELSR_OFF_EP_STS),
                               wr_fire & hit(wb_adr_i, `ELSR_OFF_RP_STS)};
    wire logic [1:0] wr_sts2 = {wr_fire & hit(wb_adr_i, `ELSR_OFF_EP_STS2),
                                wr_fire & hit(wb_adr_i, `ELSR_OFF_RP_STS2)};

    // ****************************************************************
    // Control register
    // ****************************************************************
    logic dis_reg;
    logic sbr_reg;
    logic dis_prev_reg;
    logic sbr_prev_reg;
    logic retrain_reg;
    logic rst_seen_reg;
    elsr_pkg::elsr_speed_t rp_tgt_reg;
    elsr_pkg::elsr_speed_t ep_tgt_reg;
    elsr_pkg::elsr_speed_t cur_speed_reg;

    wire logic dis_next = (wr_ctrl & wb_sel_i[0]) ? wb_dat_i[`ELSR_CTRL_DIS] : dis_reg;
    wire logic sbr_next = (wr_ctrl & wb_sel_i[0]) ? wb_dat_i[`ELSR_CTRL_SBR] : sbr_reg;
    wire elsr_pkg::elsr_speed_t rp_tgt_next = (wr_ctrl & wb_sel_i[0]) ? wb_dat_i[7:4]
                                                                      : rp_tgt_reg;
    wire elsr_pkg::elsr_speed_t ep_tgt_next = (wr_ctrl & wb_sel_i[1]) ? wb_dat_i[11:8]
                                                                      : ep_tgt_reg;
    // Current speed trails the targets by one cycle
    wire elsr_pkg::elsr_speed_t cur_speed_next = (rp_tgt_reg < ep_tgt_reg) ? rp_tgt_reg
                                                                            : ep_tgt_reg;

    always_ff @(posedge clk_sys_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            dis_reg <= 1'b0;
            sbr_reg <= 1'b0;
            dis_prev_reg <= 1'b0;
            sbr_prev_reg <= 1'b0;
            retrain_reg <= 1'b0;
            rst_seen_reg <= 1'b0;
            rp_tgt_reg <= `ELSR_TGT_RST;
            ep_tgt_reg <= `ELSR_TGT_RST;
            cur_speed_reg <= `ELSR_TGT_RST;
        end else begin
            dis_reg <= dis_next;
            sbr_reg <= sbr_next;
            dis_prev_reg <= dis_reg;
            sbr_prev_reg <= sbr_reg;
            // Retrain is a strobe and always reads back as zero
            retrain_reg <= wr_ctrl & wb_sel_i[0] & wb_dat_i[`ELSR_CTRL_RETRAIN];
            rst_seen_reg <= 1'b1;
            rp_tgt_reg <= rp_tgt_next;
            ep_tgt_reg <= ep_tgt_next;
            cur_speed_reg <= cur_speed_next;
        end
    end

    // ****************************************************************
    // Release events and delay timers
    // ****************************************************************
    // Either hold keeps the endpoint in reset and the link down
    wire logic hold = dis_reg | sbr_reg;
    wire logic dis_rise = dis_reg & ~dis_prev_reg;
    wire logic sbr_rise = sbr_reg & ~sbr_prev_reg;
    wire logic dis_fall = ~dis_reg & dis_prev_reg;
    wire logic sbr_fall = ~sbr_reg & sbr_prev_reg;
    // Reset release arms its timer on the first edge after reset
    wire logic [3:0] dly_start = {retrain_reg, sbr_fall, dis_fall, ~rst_seen_reg};
    wire logic [3:0] dly_abort = {1'b0, {3{dis_rise | sbr_rise}}};
    wire logic [3:0] dly_go = dly_start & ~dly_abort;
    localparam elsr_pkg::elsr_cnt_t DLY_CYC [4] = '{
        12'(`ELSR_CYC(`ELSR_RST_DLY_NS)),
        12'(`ELSR_CYC(`ELSR_DIS_DLY_NS)),
        12'(`ELSR_CYC(`ELSR_SBR_DLY_NS)),
        12'(`ELSR_CYC(`ELSR_RTR_DLY_NS))
    };
    logic [3:0] dly_done;
    logic [3:0] dly_busy;

    genvar g;
    generate
        for (g = 0; g < 4; g++) begin : g_dly
            elsr_dly_if dly_bus ();
            assign dly_bus.start = dly_start[g];
            assign dly_bus.abort = dly_abort[g];
            assign dly_done[g] = dly_bus.done;
            assign dly_busy[g] = dly_bus.busy;
            elsr_delay #(
                .CYC(DLY_CYC[g])
            ) u_dly (
                .clk_sys_i(clk_sys_i),
                .rst_b_i(rst_b_i),
                .dly(dly_bus)
            );
        end
    endgenerate

    // ****************************************************************
    // Link active and equalization
    // ****************************************************************
    logic active_reg;
    logic up_pend_reg;
    logic eq_reg;
    // Declared here as the presence code reads the root port flag
    logic [1:0] drs_reg;
    // A release while the other hold is still set must not bring the link up
    wire logic up_done = (dly_done[elsr_pkg::ELSR_DLY_RST] |
                          dly_done[elsr_pkg::ELSR_DLY_DIS] |
                          dly_done[elsr_pkg::ELSR_DLY_SBR]) & ~hold;
    localparam logic [6:0] SUP_VEC = `ELSR_SUP_SPEEDS;
    wire logic sup_8g = SUP_VEC[`ELSR_SUP_8G_BIT];
    wire logic active_next = hold ? 1'b0 :
                             up_pend_reg ? 1'b1 : active_reg;
    // Flags drop when a hold ends so that they rise again ahead of link-up
    wire logic eq_next = (up_done & sup_8g) ? 1'b1 :
                         (dis_fall | sbr_fall) ? 1'b0 : eq_reg;
    wire logic speed_ok = (cur_speed_reg >= `ELSR_SPEED_5G);
    wire logic active_vis = active_reg & speed_ok;
    wire logic training = |dly_busy;
    wire logic [2:0] pres_rp = ~active_reg ? `ELSR_PRES_DOWN :
                               drs_reg[0] ? `ELSR_PRES_UP_DRS : `ELSR_PRES_UP;

    always_ff @(posedge clk_sys_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            active_reg <= 1'b0;
            up_pend_reg <= 1'b0;
            eq_reg <= 1'b0;
            link_active_o <= 1'b0;
        end else begin
            active_reg <= active_next;
            // One cycle of margin lets equalization flags lead link-active
            up_pend_reg <= up_done;
            eq_reg <= eq_next;
            link_active_o <= active_next & speed_ok;
        end
    end

    // ****************************************************************
    // Per-port sticky flags
    // ****************************************************************
    logic [1:0] bw_reg;
    logic [1:0] abw_reg;
    wire logic [1:0] bw_set = {1'b0, dly_done[elsr_pkg::ELSR_DLY_RTR]};
    wire logic [1:0] abw_set = {1'b0, up_done};

    generate
        for (g = 0; g < 2; g++) begin : g_port
            // Set wins over a write-one-to-clear in the same cycle
            wire logic bw_clr = wr_sts[g] & wbits[`ELSR_STS_BW];
            wire logic abw_clr = wr_sts[g] & wbits[`ELSR_STS_ABW];
            wire logic drs_clr = wr_sts2[g] & wbits[`ELSR_STS2_DRS];
            always_ff @(posedge clk_sys_i or negedge rst_b_i) begin
                if (!rst_b_i) begin
                    bw_reg[g] <= 1'b0;
                    abw_reg[g] <= 1'b0;
                    drs_reg[g] <= 1'b0;
                end else begin
                    bw_reg[g] <= bw_set[g] | (bw_reg[g] & ~bw_clr);
                    abw_reg[g] <= abw_set[g] | (abw_reg[g] & ~abw_clr);
                    drs_reg[g] <= drs_msg_i[g] | (drs_reg[g] & ~drs_clr);
                end
            end
        end
    endgenerate

    // ****************************************************************
    // Read words
    // ****************************************************************
    wire logic rp_drs_sup = `ELSR_EP_DRS_SUP | `ELSR_EP_FRS_SUP;
    wire logic [15:0] sts_rp = {abw_reg[0], bw_reg[0], active_vis, 1'b0, training, 1'b0,
                                `ELSR_LINK_WIDTH, cur_speed_reg};
    wire logic [15:0] sts_ep = {abw_reg[1], bw_reg[1], active_vis, 1'b0, training, 1'b0,
                                `ELSR_LINK_WIDTH, cur_speed_reg};
    wire logic [31:0] cap2_rp = {rp_drs_sup, 23'h00_0000, `ELSR_SUP_SPEEDS, 1'b0};
    wire logic [31:0] cap2_ep = {`ELSR_EP_DRS_SUP, 23'h00_0000, `ELSR_SUP_SPEEDS, 1'b0};
    // Equalization request, retimer flags and crosslink resolution are constant zero
    wire logic [15:0] sts2_rp = {drs_reg[0], pres_rp, 4'h0, 3'h0, {4{eq_reg}},
                                 `ELSR_DEEMPH};
    wire logic [15:0] sts2_ep = {drs_reg[1], `ELSR_PRES_EP, 4'h0, 3'h0, {4{eq_reg}},
                                 `ELSR_DEEMPH};
    wire logic [31:0] ctrl_rd = {20'h0_0000, ep_tgt_reg, rp_tgt_reg, 2'b00, sbr_reg, dis_reg};

    // Unmapped words read as zero and writes to them are dropped
    assign rd_word = hit(wb_adr_i, `ELSR_OFF_RP_STS) ? {16'h0000, sts_rp} :
                     hit(wb_adr_i, `ELSR_OFF_EP_STS) ? {16'h0000, sts_ep} :
                     hit(wb_adr_i, `ELSR_OFF_RP_CAP2) ? cap2_rp :
                     hit(wb_adr_i, `ELSR_OFF_EP_CAP2) ? cap2_ep :
                     hit(wb_adr_i, `ELSR_OFF_RP_STS2) ? {16'h0000, sts2_rp} :
                     hit(wb_adr_i, `ELSR_OFF_EP_STS2) ? {16'h0000, sts2_ep} :
                     hit(wb_adr_i, `ELSR_OFF_CTRL) ? ctrl_rd : 32'h0000_0000;

    always_ff @(posedge clk_sys_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            ack_reg <= 1'b0;
            dat_reg <= 32'h0000_0000;
        end else begin
            // Ack every other cycle, so a strobe held past its ack is taken again two cycles later
            ack_reg <= req & ~ack_reg;
            dat_reg <= (req & ~ack_reg) ? rd_word : 32'h0000_0000;
        end
    end

    assign wb_ack_o = ack_reg;
    assign wb_dat_o = dat_reg;

    // ****************************************************************
    // Assertions
    // ****************************************************************
    // Window bounds: timer length plus done, pend and active stages, done and flag stages for retrain, one spare cycle for reset
    localparam int RTR_MAX = `ELSR_CYC(`ELSR_RTR_DLY_NS) + 2;
    localparam int DIS_MAX = `ELSR_CYC(`ELSR_DIS_DLY_NS) + 3;
    localparam int RST_MAX = `ELSR_CYC(`ELSR_RST_DLY_NS) + 4;
    localparam int SBR_MAX = `ELSR_CYC(`ELSR_SBR_DLY_NS) + 3;

    a_speed_gate_low: assert property (@(posedge clk_sys_i) disable iff (!rst_b_i)
        !speed_ok |-> !sts_rp[13] && !sts_ep[13])
        else $error("link active shown below 5 GT/s");

    a_ports_same_active: assert property (@(posedge clk_sys_i) disable iff (!rst_b_i)
        sts_rp[13] == sts_ep[13] && sts_rp[3:0] == sts_ep[3:0])
        else $error("root port and endpoint disagree");

    a_hold_forces_low: assert property (@(posedge clk_sys_i) disable iff (!rst_b_i)
        (dis_rise || sbr_rise) |=> !active_reg [*2])
        else $error("link active not cleared on hold");

    a_eq_leads_active: assert property (@(posedge clk_sys_i) disable iff (!rst_b_i)
        $rose(active_reg) |-> $past(eq_reg) == sup_8g)
        else $error("equalization flags not set before link active");

    a_pres_legal: assert property (@(posedge clk_sys_i) disable iff (!rst_b_i)
        pres_rp == 3'h2 || pres_rp == 3'h4 || pres_rp == 3'h5)
        else $error("illegal presence code");

    a_pres_up_down: assert property (@(posedge clk_sys_i) disable iff (!rst_b_i)
        ($rose(active_reg) |-> ($past(pres_rp) == 3'h2 && pres_rp[2])) and
        ($fell(active_reg) |-> ($past(pres_rp[2]) && pres_rp == 3'h2)))
        else $error("presence did not follow link state");

    a_retrain_sets_bw: assert property (@(posedge clk_sys_i) disable iff (!rst_b_i)
        retrain_reg |-> ##[1:RTR_MAX] bw_reg[0])
        else $error("bandwidth management flag not set after retrain");

    a_dis_release_up: assert property (@(posedge clk_sys_i) disable iff (!rst_b_i)
        dis_fall |-> ##[1:DIS_MAX] (active_reg || hold || dis_rise || sbr_fall))
        else $error("link not up after link disable release");

    a_const_fields: assert property (@(posedge clk_sys_i) disable iff (!rst_b_i)
        cap2_rp[24:8] == 17'h0_0000 && sts2_rp[9:5] == 5'h00 && sts2_ep[9:5] == 5'h00)
        else $error("hardwired field not zero");

    a_drs_support: assert property (@(posedge clk_sys_i) disable iff (!rst_b_i)
        (cap2_ep[31] || `ELSR_EP_FRS_SUP) |-> cap2_rp[31])
        else $error("root port lacks DRS support");

    a_speed_min: assert property (@(posedge clk_sys_i) disable iff (!rst_b_i)
        $stable(rp_tgt_reg) && $stable(ep_tgt_reg) |->
        cur_speed_reg == ((rp_tgt_reg < ep_tgt_reg) ? rp_tgt_reg : ep_tgt_reg))
        else $error("current speed is not the lower target");

    a_rst_release_up: assert property (@(posedge clk_sys_i) disable iff (!rst_b_i)
        !rst_seen_reg |-> ##[1:RST_MAX] (active_reg || hold))
        else $error("link not up after reset release");

    a_sbr_release_up: assert property (@(posedge clk_sys_i) disable iff (!rst_b_i)
        sbr_fall |-> ##[1:SBR_MAX] (active_reg || hold))
        else $error("link not up after secondary bus reset release");

    a_start_arms_timer: assert property (@(posedge clk_sys_i) disable iff (!rst_b_i)
        dly_go != 4'h0 |=>
        (dly_busy & $past(dly_go)) == $past(dly_go))
        else $error("release event did not start its timer");

    a_out_speed_gate: assert property (@(posedge clk_sys_i) disable iff (!rst_b_i)
        !speed_ok |=> !link_active_o)
        else $error("link active output set below 5 GT/s");

    a_drs_msg_sets: assert property (@(posedge clk_sys_i) disable iff (!rst_b_i)
        (drs_msg_i[0] |=> drs_reg[0]) and (drs_msg_i[1] |=> drs_reg[1]))
        else $error("DRS message did not set its flag");
endmodule // elsr_top

// ---- sim/elsr_tb.sv ----
// Self-checking testbench of the emulated link status register block
`timescale 1ns/10ps
`include "elsr_consts.svh"
module testbench;
    // ****************************************************************
    // Signals and expected constants
    // ****************************************************************
    localparam logic [6:0] SUP = `ELSR_SUP_SPEEDS;
    localparam logic [3:0] EQ_UP = SUP[`ELSR_SUP_8G_BIT] ? 4'hf : 4'h0;
    localparam int RST_CYC = `ELSR_CYC(`ELSR_RST_DLY_NS);
    localparam int DIS_CYC = `ELSR_CYC(`ELSR_DIS_DLY_NS);
    localparam int SBR_CYC = `ELSR_CYC(`ELSR_SBR_DLY_NS);
    localparam int RTR_CYC = `ELSR_CYC(`ELSR_RTR_DLY_NS);
    localparam logic [31:0] M_STS = 32'hffff_37ff;
    localparam logic [31:0] ALL = 32'hffff_ffff;
    logic clk_sys_i = 1'b0;
    logic rst_b_i = 1'b0;
    logic wb_cyc_i = 1'b0;
    logic wb_stb_i = 1'b0;
    logic wb_we_i = 1'b0;
    logic [7:0] wb_adr_i = 8'h00;
    logic [3:0] wb_sel_i = 4'h0;
    logic [31:0] wb_dat_i = 32'h0000_0000;
    logic [31:0] wb_dat_o;
    logic wb_ack_o;
    logic [1:0] drs_msg_i = 2'b00;
    logic link_active_o;
    int mismatches = 0;
    int cmp_count = 0;
    int cyc = 0;
    int t0;
    int seed;
    int dly;
    logic [31:0] rd;
    logic [31:0] bitv;
    logic [3:0] t_rp;
    logic [3:0] t_ep;
    logic [3:0] spd;

    always #2 clk_sys_i = ~clk_sys_i;
    always @(posedge clk_sys_i) cyc <= cyc + 1;

    elsr_top dut_u (
        .clk_sys_i(clk_sys_i), .rst_b_i(rst_b_i), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
        .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i),
        .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .drs_msg_i(drs_msg_i),
        .link_active_o(link_active_o)
    );

    // ****************************************************************
    // Expectations
    // ****************************************************************
    function automatic logic [31:0] exp_sts(input logic [3:0] s, input logic act);
        exp_sts = {18'h0_0000, act, 3'h0, `ELSR_LINK_WIDTH, s};
    endfunction
    function automatic logic [31:0] exp_sts2(input logic [3:0] eq, input logic [2:0] p,
                                             input logic drs);
        exp_sts2 = {16'h0000, drs, p, 7'h00, eq, `ELSR_DEEMPH};
    endfunction
    function automatic logic [31:0] exp_cap2(input logic rp);
        logic drs;
        drs = rp ? (`ELSR_EP_DRS_SUP | `ELSR_EP_FRS_SUP) : `ELSR_EP_DRS_SUP;
        exp_cap2 = {drs, 23'h00_0000, SUP, 1'b0};
    endfunction
    function automatic logic [3:0] min_spd(input logic [3:0] a, input logic [3:0] b);
        min_spd = (a < b) ? a : b;
    endfunction

    // ****************************************************************
    // Bus and compare tasks
    // ****************************************************************
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        cmp_count++;
        if (got !== exp) begin
            mismatches++;
            $display("BAD %0t got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic chk_rng(input int n, input int lo, input int hi);
        cmp_count++;
        if (n < lo || n > hi) begin
            mismatches++;
            $display("BAD %0t delay %0d outside %0d..%0d", $time, n, lo, hi);
        end
    endtask
    task automatic wb_xfer(input logic we, input logic [7:0] a, input logic [31:0] d,
                           input logic [3:0] s);
        int k;
        @(posedge clk_sys_i);
        wb_cyc_i <= 1'b1;
        wb_stb_i <= 1'b1;
        wb_we_i <= we;
        wb_adr_i <= a;
        wb_sel_i <= s;
        wb_dat_i <= d;
        for (k = 0; k < 50; k++) begin
            @(posedge clk_sys_i);
            if (wb_ack_o === 1'b1) break;
        end
        rd = wb_dat_o;
        if (k == 50) chk(32'h0000_0000, 32'hffff_ffff);
        wb_cyc_i <= 1'b0;
        wb_stb_i <= 1'b0;
        wb_we_i <= 1'b0;
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [3:0] s);
        wb_xfer(1'b1, a, d, s);
    endtask
    task automatic rd_chk(input logic [7:0] a, input logic [31:0] e, input logic [31:0] m);
        wb_xfer(1'b0, a, 32'h0000_0000, 4'hf);
        chk(rd & m, e & m);
    endtask
    task automatic wait_up(input int lim);
        while (link_active_o !== 1'b1 && cyc - t0 < lim) @(posedge clk_sys_i);
    endtask
    task automatic stop_test();
        if (mismatches == 0 && cmp_count > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask

    initial begin
        #200000;
        mismatches++;
        stop_test();
    end

    // ****************************************************************
    // Scenarios
    // ****************************************************************
    initial begin
        seed = $urandom(32'h8ad8);
        repeat (10) @(posedge clk_sys_i);
        rst_b_i <= 1'b1;
        t0 = cyc;
        rd_chk(`ELSR_OFF_CTRL, 32'h0000_0330, ALL);
        rd_chk(`ELSR_OFF_RP_STS, exp_sts(4'h3, 1'b0), M_STS);
        rd_chk(`ELSR_OFF_RP_STS2, exp_sts2(4'h0, `ELSR_PRES_DOWN, 1'b0), ALL);
        for (int i = 0; i < 2; i++) begin
            wr(`ELSR_OFF_RP_CAP2 + 8'(4 * i), ALL, 4'hf);
            rd_chk(`ELSR_OFF_RP_CAP2 + 8'(4 * i), exp_cap2(i == 0), ALL);
        end
        // Unmapped places ack, read zero and keep nothing
        wr(8'h1c, ALL, 4'hf);
        rd_chk(8'h1c, 32'h0000_0000, ALL);
        rd_chk(8'hfc, 32'h0000_0000, ALL);
        wait_up(RST_CYC + 50);
        chk_rng(cyc - t0, RST_CYC - 2, RST_CYC + 8);
        for (int i = 0; i < 2; i++) begin
            rd_chk(`ELSR_OFF_RP_STS + 8'(4 * i), exp_sts(4'h3, 1'b1), M_STS);
            rd_chk(`ELSR_OFF_RP_STS2 + 8'(4 * i), exp_sts2(EQ_UP, i ? `ELSR_PRES_EP :
                   `ELSR_PRES_UP, 1'b0), ALL);
        end
        // Link disable, then secondary bus reset; a second release restarts the timer
        for (int j = 0; j < 2; j++) begin
            bitv = (j == 0) ? 32'h0000_0001 : 32'h0000_0002;
            dly = (j == 0) ? DIS_CYC : SBR_CYC;
            wr(`ELSR_OFF_CTRL, 32'h0000_0330 | bitv, 4'hf);
            rd_chk(`ELSR_OFF_RP_STS, exp_sts(4'h3, 1'b0), M_STS);
            rd_chk(`ELSR_OFF_EP_STS, exp_sts(4'h3, 1'b0), M_STS);
            rd_chk(`ELSR_OFF_RP_STS2, exp_sts2(4'h0, `ELSR_PRES_DOWN, 1'b0),
                   32'hffff_ffe1);
            wr(`ELSR_OFF_CTRL, 32'h0000_0330, 4'hf);
            rd_chk(`ELSR_OFF_RP_STS2, exp_sts2(4'h0, `ELSR_PRES_DOWN, 1'b0), ALL);
            repeat (dly / 2) @(posedge clk_sys_i);
            wr(`ELSR_OFF_CTRL, 32'h0000_0330 | bitv, 4'hf);
            wr(`ELSR_OFF_CTRL, 32'h0000_0330, 4'hf);
            t0 = cyc;
            wait_up(dly + 50);
            chk_rng(cyc - t0, dly - 2, dly + 8);
            rd_chk(`ELSR_OFF_RP_STS2, exp_sts2(EQ_UP, `ELSR_PRES_UP, 1'b0), ALL);
        end
        // Retrain sets the root port bandwidth flag after its delay
        wr(`ELSR_OFF_CTRL, 32'h0000_0334, 4'hf);
        t0 = cyc;
        rd_chk(`ELSR_OFF_RP_STS, 32'h0000_0000, 32'h0000_4000);
        while (rd[14] !== 1'b1 && cyc - t0 < RTR_CYC + 40) begin
            wb_xfer(1'b0, `ELSR_OFF_RP_STS, 32'h0000_0000, 4'hf);
        end
        chk_rng(cyc - t0, RTR_CYC, RTR_CYC + 12);
        rd_chk(`ELSR_OFF_CTRL, 32'h0000_0330, ALL);
        rd_chk(`ELSR_OFF_EP_STS, 32'h0000_0000, 32'h0000_4000);
        wr(`ELSR_OFF_RP_STS, 32'h0000_c000, 4'h3);
        rd_chk(`ELSR_OFF_RP_STS, 32'h0000_0000, 32'h0000_c000);
        // Random target speeds with both slow corners first
        for (int i = 0; i < 8; i++) begin
            t_rp = (i == 0) ? 4'h1 : 4'($urandom_range(1, 3));
            t_ep = (i == 1) ? 4'h1 : 4'($urandom_range(1, 3));
            spd = min_spd(t_rp, t_ep);
            wr(`ELSR_OFF_CTRL, {20'h0_0000, t_ep, t_rp, 4'h0}, 4'hf);
            rd_chk(`ELSR_OFF_RP_STS, exp_sts(spd, spd >= `ELSR_SPEED_5G), M_STS);
            rd_chk(`ELSR_OFF_EP_STS, exp_sts(spd, spd >= `ELSR_SPEED_5G), M_STS);
            chk({31'h0, link_active_o}, {31'h0, spd >= `ELSR_SPEED_5G});
        end
        wr(`ELSR_OFF_CTRL, 32'h0000_0330, 4'hf);
        rd_chk(`ELSR_OFF_RP_STS, exp_sts(4'h3, 1'b1), M_STS);
        // DRS message flags, write one to clear
        for (int i = 0; i < 2; i++) begin
            @(posedge clk_sys_i);
            drs_msg_i <= 2'(1 << i);
            @(posedge clk_sys_i);
            drs_msg_i <= 2'b00;
            rd_chk(`ELSR_OFF_RP_STS2 + 8'(4 * i), exp_sts2(EQ_UP, i ? `ELSR_PRES_EP :
                   `ELSR_PRES_UP_DRS, 1'b1), ALL);
            rd_chk(`ELSR_OFF_RP_STS2 + 8'(4 - 4 * i), 32'h0000_0000, 32'h0000_8000);
            wr(`ELSR_OFF_RP_STS2 + 8'(4 * i), 32'h0000_8000, 4'h3);
            rd_chk(`ELSR_OFF_RP_STS2 + 8'(4 * i), exp_sts2(EQ_UP, i ? `ELSR_PRES_EP :
                   `ELSR_PRES_UP, 1'b0), ALL);
        end
        // Second reset in mid-run
        @(posedge clk_sys_i);
        rst_b_i <= 1'b0;
        @(posedge clk_sys_i);
        chk({31'h0, link_active_o}, 32'h0000_0000);
        rst_b_i <= 1'b1;
        t0 = cyc;
        wait_up(RST_CYC + 50);
        chk_rng(cyc - t0, RST_CYC - 2, RST_CYC + 8);
        stop_test();
    end
endmodule // testbench
